// File: tread_pkg.sv
package tread_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int BAUD = 4800;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int HALF_CYC = BIT_CYC / 2;
  localparam int LOSS_MS = 500;
  localparam int LOSS_CYC = CLK_HZ / 1000 * LOSS_MS;
  localparam int GUARD_MS = 3000;
  localparam int GUARD_CYC = CLK_HZ / 1000 * GUARD_MS;
  localparam int SILENT_MS = 20000;
  localparam int SILENT_CYC = CLK_HZ / 1000 * SILENT_MS;
  localparam int DATA_BITS = 8;
  localparam logic [7:0] CMD_START_ARM = 8'hA0;
  localparam logic [7:0] CMD_START_FREE = 8'hA1;
  localparam logic [7:0] CMD_STOP = 8'hA2;
  localparam logic [7:0] CMD_SPEED = 8'hA3;
  localparam logic [7:0] CMD_ELEV = 8'hA4;
  localparam logic [7:0] CMD_TIME = 8'hA5;
  localparam logic [7:0] CMD_PROTO = 8'hA6;
  localparam logic [7:0] CMD_STAGE = 8'hA7;
  localparam logic [7:0] CMD_RESET_TOT = 8'hA8;
  localparam logic [7:0] CMD_WEIGHT = 8'hA9;
  localparam logic [7:0] CMD_AUTO_STOP = 8'hAA;
  localparam logic [7:0] CMD_COOL = 8'hAB;
  localparam logic [7:0] CMD_ECHO = 8'hAC;
  localparam logic [7:0] ACK_OFFSET = 8'h10;
  localparam logic [7:0] ACK_RANGE = 8'hBE;
  localparam logic [7:0] ACK_ILLEGAL = 8'hBF;
  localparam logic [7:0] REQ_BELT = 8'hC0;
  localparam logic [7:0] REQ_ACT_SPEED = 8'hC1;
  localparam logic [7:0] REQ_ACT_ELEV = 8'hC2;
  localparam logic [7:0] REQ_SET_SPEED = 8'hC3;
  localparam logic [7:0] REQ_SET_ELEV = 8'hC4;
  localparam logic [7:0] REQ_PROTO = 8'hC8;
  localparam logic [7:0] REQ_STAGE = 8'hC9;
  localparam logic [7:0] REQ_LAST = 8'hCD;
  localparam logic [7:0] BELT_STOPPED = 8'h31;
  localparam logic [7:0] BELT_ARMED = 8'h32;
  localparam logic [7:0] BELT_FREE = 8'h33;
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_NINE = 8'h39;
  localparam logic [7:0] ASCII_FIVE = 8'h35;
  localparam logic [2:0] LEN_FOUR = 3'h4;
  localparam logic [2:0] LEN_TWO = 3'h2;
  localparam logic [2:0] LEN_ONE = 3'h1;
  localparam logic [2:0] LEN_NONE = 3'h0;
  localparam logic [31:0] ZERO_FIELD = 32'h30303030;

  typedef struct packed {
    logic [31:0] actualSpeed;
    logic [31:0] actualElev;
  } meas_t;

  typedef struct packed {
    logic [31:0] setSpeed;
    logic [31:0] setElev;
    logic beltRun;
    logic lossArmed;
    logic echoOn;
  } ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DATA = 3'h1,
    ST_SEND = 3'h2,
    ST_WAIT = 3'h3,
    ST_MUTE = 3'h4
  } cmd_state_t;
endpackage

// File: uart_core.sv
`timescale 1ns/1ps
module uart_core
  import tread_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial pins
  input wire logic rxPin,
  output logic txPin,
  // Received bytes
  output logic [7:0] rxData,
  output logic rxValid,
  // Bytes to send
  input wire logic [7:0] txData,
  input wire logic txStart,
  output logic txBusy
);
  logic sync1_r, sync2_r, sync1_nxt, sync2_nxt;
  logic rxAct_r, rxAct_nxt, rxValid_r, rxValid_nxt;
  logic [15:0] rxCnt_r, rxCnt_nxt, txCnt_r, txCnt_nxt;
  logic [3:0] rxBit_r, rxBit_nxt, txBit_r, txBit_nxt;
  logic [7:0] rxSh_r, rxSh_nxt, rxData_r, rxData_nxt;
  logic [9:0] txSh_r, txSh_nxt;
  logic txAct_r, txAct_nxt;

  assign rxData = rxData_r;
  assign rxValid = rxValid_r;
  assign txPin = txSh_r[0];
  assign txBusy = txAct_r;

  // Independent receiver and transmitter give full duplex
  always_comb begin
    sync1_nxt = rxPin;
    sync2_nxt = sync1_r;
    rxAct_nxt = rxAct_r;
    rxCnt_nxt = rxCnt_r;
    rxBit_nxt = rxBit_r;
    rxSh_nxt = rxSh_r;
    rxData_nxt = rxData_r;
    rxValid_nxt = 1'b0;
    if (!rxAct_r) begin
      if (!sync2_r) begin
        rxAct_nxt = 1'b1;
        rxCnt_nxt = 16'(HALF_CYC);
        rxBit_nxt = 4'h0;
      end
    end else if (rxCnt_r != 16'h0000) begin
      rxCnt_nxt = rxCnt_r - 16'h0001;
    end else begin
      rxCnt_nxt = 16'(BIT_CYC - 1);
      rxBit_nxt = rxBit_r + 4'h1;
      if (rxBit_r == 4'h0) begin
        if (sync2_r) rxAct_nxt = 1'b0;
      end else if (rxBit_r <= 4'(DATA_BITS)) begin
        rxSh_nxt = {sync2_r, rxSh_r[7:1]};
      end else begin
        rxAct_nxt = 1'b0;
        if (sync2_r) begin
          rxData_nxt = rxSh_r;
          rxValid_nxt = 1'b1;
        end
      end
    end
    txAct_nxt = txAct_r;
    txCnt_nxt = txCnt_r;
    txBit_nxt = txBit_r;
    txSh_nxt = txSh_r;
    if (!txAct_r) begin
      if (txStart) begin
        txAct_nxt = 1'b1;
        txSh_nxt = {1'b1, txData, 1'b0};
        txCnt_nxt = 16'(BIT_CYC - 1);
        txBit_nxt = 4'h0;
      end
    end else if (txCnt_r != 16'h0000) begin
      txCnt_nxt = txCnt_r - 16'h0001;
    end else begin
      txCnt_nxt = 16'(BIT_CYC - 1);
      txSh_nxt = {1'b1, txSh_r[9:1]};
      txBit_nxt = txBit_r + 4'h1;
      if (txBit_r == 4'(DATA_BITS + 1)) txAct_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      rxAct_r <= 1'b0;
      rxCnt_r <= 16'h0000;
      rxBit_r <= 4'h0;
      rxSh_r <= 8'h00;
      rxData_r <= 8'h00;
      rxValid_r <= 1'b0;
      txAct_r <= 1'b0;
      txCnt_r <= 16'h0000;
      txBit_r <= 4'h0;
      txSh_r <= 10'h3FF;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      rxAct_r <= rxAct_nxt;
      rxCnt_r <= rxCnt_nxt;
      rxBit_r <= rxBit_nxt;
      rxSh_r <= rxSh_nxt;
      rxData_r <= rxData_nxt;
      rxValid_r <= rxValid_nxt;
      txAct_r <= txAct_nxt;
      txCnt_r <= txCnt_nxt;
      txBit_r <= txBit_nxt;
      txSh_r <= txSh_nxt;
    end
  end
endmodule

// File: treadmill_cmd.sv
`timescale 1ns/1ps
// How it works
// [RULE_01] Serial link is 4800 baud, 8 data bits, no parity, one stop, full duplex.
// [RULE_02] Bytes go out only as a reply, after the command is executed.
// [RULE_03] A0 starts belt with loss stop armed; reply B0.
// [RULE_04] A1 starts belt with loss stop disarmed; reply B1.
// [RULE_05] A2 stops belt; AA zeroes set points, stops belt, replies BA.
// [RULE_06] AB zeroes set points, belt keeps running; reply BB.
// [RULE_07] A3 takes four ASCII bytes of new speed; reply B3.
// [RULE_08] Speeds are four ASCII decimal digits, most significant first.
// [RULE_09] A4 takes four ASCII bytes of elevation; reply B4.
// [RULE_10] Elevation last digit must be '0' or '5', else reply BE.
// [RULE_11] Unknown command byte gets reply BF.
// [RULE_12] A5 to A9 accepted with data, no action; queries give zero.
// [RULE_13] Replies B5 to B9 carry zero data.
// [RULE_14] C0 to CD answered D0 to DD; D1 to D4 carry four bytes.
// [RULE_15] Belt status: 31h stopped, 32h armed run, 33h free run.
// [RULE_16] C5 to CD replies always carry zero data.
// [RULE_17] D8 and D9 carry two bytes, other data replies four; the code sends D0 with one byte.
// [RULE_18] Echo flag clear at reset; AC toggles it, reply BC.
// [RULE_19] With echo on, the received command string follows each reply.
// [RULE_20] Armed belt stops if no command within 0.5 s.
// [RULE_21] Start commands within 3 s of zero found are rejected.
// [RULE_22] After a rejection, starts rejected until reset, stop or 20 s silence.
// [RULE_23] Start during zero search makes device mute until timeout or stop.
// [RULE_24] Non-digit numeric byte answers BE, set points unchanged.
module treadmill_cmd
  import tread_pkg::*;
#(
  parameter int LOSS_LIMIT = LOSS_CYC,
  parameter int GUARD_LIMIT = GUARD_CYC,
  parameter int SILENT_LIMIT = SILENT_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial pins
  input wire logic rxPin,
  output logic txPin,
  // Status from the rest of the control board
  input wire logic zeroFound,
  input wire meas_t meas,
  // Control outputs
  output ctrl_t ctrl,
  output logic startRejected,
  output logic muted
);
  logic [7:0] rxData, txData;
  logic rxValid, txStart, txBusy;

  uart_core uart (
    .clk(clk),
    .reset(reset),
    .rxPin(rxPin),
    .txPin(txPin),
    .rxData(rxData),
    .rxValid(rxValid),
    .txData(txData),
    .txStart(txStart),
    .txBusy(txBusy)
  ); // RULE_01

  function automatic logic [2:0] inLen(input logic [7:0] c);
    case (c)
      CMD_SPEED, CMD_ELEV, CMD_TIME, CMD_WEIGHT: inLen = LEN_FOUR;
      CMD_PROTO, CMD_STAGE: inLen = LEN_TWO;
      default: inLen = LEN_NONE;
    endcase
  endfunction

  function automatic logic isDigit(input logic [7:0] b);
    isDigit = (b >= ASCII_ZERO) && (b <= ASCII_NINE);
  endfunction

  ////////////////////////////////////////////////////////////
  cmd_state_t state_r, state_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic bad_r, bad_nxt;
  logic [7:0] buf_r [0:10];
  logic [7:0] buf_nxt [0:10];
  logic [3:0] len_r, len_nxt, idx_r, idx_nxt;
  ctrl_t ctrl_r, ctrl_nxt;
  logic [31:0] lossCnt_r, lossCnt_nxt, guardCnt_r, guardCnt_nxt, silentCnt_r, silentCnt_nxt;
  logic reject_r, reject_nxt, mute_r, mute_nxt, zeroSeen_r, zeroSeen_nxt;
  logic zs1_r, zs2_r;
  logic [7:0] reply;
  logic [31:0] field;
  logic [2:0] flen, ilen;
  logic cmdDone, isStop;

  assign ctrl = ctrl_r;
  assign startRejected = reject_r;
  assign muted = mute_r;
  assign txData = buf_r[idx_r];
  assign txStart = (state_r == ST_SEND) && !txBusy;

  always_comb begin
    state_nxt = state_r;
    cmd_nxt = cmd_r;
    dat_nxt = dat_r;
    cnt_nxt = cnt_r;
    bad_nxt = bad_r;
    buf_nxt = buf_r;
    len_nxt = len_r;
    idx_nxt = idx_r;
    ctrl_nxt = ctrl_r;
    reject_nxt = reject_r;
    mute_nxt = mute_r;
    zeroSeen_nxt = zeroSeen_r | zs2_r;
    cmdDone = 1'b0;
    reply = ACK_ILLEGAL;
    field = ZERO_FIELD;
    flen = LEN_NONE;
    ilen = inLen(cmd_r);
    isStop = (rxData == CMD_STOP) || (rxData == CMD_AUTO_STOP);
    // Silence counters run always; any received byte restarts them
    lossCnt_nxt = rxValid ? 32'h0 : lossCnt_r + 32'h1;
    silentCnt_nxt = rxValid ? 32'h0 : silentCnt_r + 32'h1;
    // Guard runs once from the first zero report, then saturates so starts stay open
    guardCnt_nxt = (zeroSeen_r && guardCnt_r < 32'(GUARD_LIMIT)) ? guardCnt_r + 32'h1 : guardCnt_r;
    if (ctrl_r.beltRun && ctrl_r.lossArmed && lossCnt_r >= 32'(LOSS_LIMIT)) begin
      ctrl_nxt.beltRun = 1'b0; // RULE_20
      ctrl_nxt.lossArmed = 1'b0;
    end
    if (silentCnt_r >= 32'(SILENT_LIMIT)) begin
      reject_nxt = 1'b0; // RULE_22
      mute_nxt = 1'b0; // RULE_23
    end
    case (state_r)
      ST_IDLE: begin
        if (rxValid) begin
          cmd_nxt = rxData;
          cnt_nxt = inLen(rxData);
          dat_nxt = 32'h0;
          bad_nxt = 1'b0;
          if (inLen(rxData) == LEN_NONE) cmdDone = 1'b1;
          else state_nxt = ST_DATA; // RULE_07 RULE_09
        end
      end
      ST_DATA: begin
        if (rxValid) begin
          dat_nxt = {dat_r[23:0], rxData}; // RULE_08
          // One bad digit is remembered so a whole speed or elevation field is refused
          if (!isDigit(rxData)) bad_nxt = 1'b1;
          cnt_nxt = cnt_r - 3'h1;
          if (cnt_r == 3'h1) cmdDone = 1'b1;
        end
      end
      ST_SEND: begin
        // Bytes arriving now are dropped; the host must wait for the full reply
        if (!txBusy) begin
          idx_nxt = idx_r + 4'h1;
          state_nxt = (idx_r + 4'h1 == len_r) ? ST_IDLE : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!txBusy) state_nxt = ST_SEND;
      end
      ST_MUTE: begin
        // Only a stop byte is acted on here, and it gets no reply
        if (rxValid && isStop) begin
          mute_nxt = 1'b0; // RULE_23
          ctrl_nxt.beltRun = 1'b0;
        end
        if (!mute_nxt) state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
    // Execute first, then build the reply, so reply reflects new state
    if (cmdDone) begin
      if (state_r == ST_IDLE) cmd_nxt = rxData;
      ilen = inLen(cmd_nxt);
      case (cmd_nxt)
        CMD_START_ARM, CMD_START_FREE: begin
          reply = cmd_nxt + ACK_OFFSET;
          if (!zeroSeen_r) begin
            mute_nxt = 1'b1; // RULE_23
          end else if (reject_r || guardCnt_r < 32'(GUARD_LIMIT)) begin
            reject_nxt = 1'b1; // RULE_21 RULE_22
            reply = ACK_RANGE;
          end else begin
            ctrl_nxt.beltRun = 1'b1; // RULE_03 RULE_04
            ctrl_nxt.lossArmed = (cmd_nxt == CMD_START_ARM);
          end
        end
        CMD_STOP, CMD_AUTO_STOP: begin
          ctrl_nxt.beltRun = 1'b0; // RULE_05
          ctrl_nxt.lossArmed = 1'b0;
          reject_nxt = 1'b0; // RULE_22
          if (cmd_nxt == CMD_AUTO_STOP) begin
            ctrl_nxt.setSpeed = ZERO_FIELD;
            ctrl_nxt.setElev = ZERO_FIELD;
          end
          reply = cmd_nxt + ACK_OFFSET;
        end
        CMD_COOL: begin
          ctrl_nxt.setSpeed = ZERO_FIELD; // RULE_06
          ctrl_nxt.setElev = ZERO_FIELD;
          reply = cmd_nxt + ACK_OFFSET;
        end
        CMD_SPEED, CMD_ELEV: begin
          reply = cmd_nxt + ACK_OFFSET;
          if (bad_nxt || !isDigit(rxData)) reply = ACK_RANGE; // RULE_24
          else if (cmd_nxt == CMD_ELEV && rxData != ASCII_ZERO && rxData != ASCII_FIVE) reply = ACK_RANGE; // RULE_10
          else if (cmd_nxt == CMD_SPEED) ctrl_nxt.setSpeed = dat_nxt; // RULE_07
          else ctrl_nxt.setElev = dat_nxt; // RULE_09
        end
        CMD_TIME, CMD_PROTO, CMD_STAGE, CMD_RESET_TOT, CMD_WEIGHT: begin
          reply = cmd_nxt + ACK_OFFSET; // RULE_12
          field = ZERO_FIELD; // RULE_13
          flen = LEN_FOUR;
        end
        CMD_ECHO: begin
          ctrl_nxt.echoOn = !ctrl_r.echoOn; // RULE_18
          reply = cmd_nxt + ACK_OFFSET;
        end
        default: begin
          if (cmd_nxt >= REQ_BELT && cmd_nxt <= REQ_LAST) begin
            reply = cmd_nxt + ACK_OFFSET; // RULE_14
            flen = (cmd_nxt == REQ_PROTO || cmd_nxt == REQ_STAGE) ? LEN_TWO : LEN_FOUR; // RULE_17
            case (cmd_nxt)
              REQ_BELT: begin
                flen = LEN_ONE;
                field = {24'h0, !ctrl_r.beltRun ? BELT_STOPPED :
                         ctrl_r.lossArmed ? BELT_ARMED : BELT_FREE}; // RULE_15
              end
              REQ_ACT_SPEED: field = meas.actualSpeed;
              REQ_ACT_ELEV: field = meas.actualElev;
              REQ_SET_SPEED: field = ctrl_r.setSpeed;
              REQ_SET_ELEV: field = ctrl_r.setElev;
              default: field = ZERO_FIELD; // RULE_16
            endcase
          end else begin
            reply = ACK_ILLEGAL; // RULE_11
          end
        end
      endcase
      // Reply, data (most significant first), then optional echo
      buf_nxt[0] = reply; // RULE_02
      // Echo slots are filled even with echo off, later slots keep stale bytes; only len of them are sent
      for (int i = 0; i < 4; i++) begin
        if (i < 32'(flen)) buf_nxt[1 + i] = field[8 * (32'(flen) - 1 - i) +: 8];
      end
      buf_nxt[1 + flen] = cmd_nxt;
      for (int i = 0; i < 4; i++) begin
        if (i < 32'(ilen)) buf_nxt[2 + flen + i] = dat_nxt[8 * (32'(ilen) - 1 - i) +: 8];
      end
      len_nxt = 4'(1 + flen);
      if (ctrl_nxt.echoOn || cmd_nxt == CMD_ECHO && ctrl_r.echoOn) begin
        len_nxt = 4'(2 + flen) + 4'(ilen); // RULE_19
      end
      idx_nxt = 4'h0;
      state_nxt = mute_nxt ? ST_MUTE : ST_SEND;
    end
  end

  ////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      cmd_r <= 8'h00;
      dat_r <= 32'h0;
      cnt_r <= 3'h0;
      bad_r <= 1'b0;
      for (int i = 0; i < 11; i++) buf_r[i] <= 8'h00;
      len_r <= 4'h0;
      idx_r <= 4'h0;
      ctrl_r <= {ZERO_FIELD, ZERO_FIELD, 3'h0}; // RULE_18
      lossCnt_r <= 32'h0;
      guardCnt_r <= 32'h0;
      silentCnt_r <= 32'h0;
      reject_r <= 1'b0;
      mute_r <= 1'b0;
      zeroSeen_r <= 1'b0;
      zs1_r <= 1'b0;
      zs2_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      dat_r <= dat_nxt;
      cnt_r <= cnt_nxt;
      bad_r <= bad_nxt;
      buf_r <= buf_nxt;
      len_r <= len_nxt;
      idx_r <= idx_nxt;
      ctrl_r <= ctrl_nxt;
      lossCnt_r <= lossCnt_nxt;
      guardCnt_r <= guardCnt_nxt;
      silentCnt_r <= silentCnt_nxt;
      reject_r <= reject_nxt;
      mute_r <= mute_nxt;
      zeroSeen_r <= zeroSeen_nxt;
      zs1_r <= zeroFound;
      zs2_r <= zs1_r;
    end
  end
endmodule

// File: tread_chk_assertions.sv
`timescale 1ns/1ps
module tread_chk
  import tread_pkg::*;
#(
  parameter int LOSS_LIMIT = LOSS_CYC,
  parameter int GUARD_LIMIT = GUARD_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pins and status
  input wire logic rxPin,
  input wire logic txPin,
  input wire logic zeroFound,
  input wire meas_t meas,
  input wire ctrl_t ctrl,
  input wire logic startRejected,
  input wire logic muted
);
  // A byte is taken at most about ten bit times after its last low level
  localparam int RX_WIN = 11 * BIT_CYC;
  // Longest reply with echo is ten frames
  localparam int TX_WIN = 120 * BIT_CYC;
  logic [23:0] idleCnt_r;
  logic [23:0] idleCnt_nxt;
  logic [31:0] zfCnt_r;
  logic [31:0] zfCnt_nxt;

  function automatic logic digits(input logic [31:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      ok &= (v[8*i+:8] >= ASCII_ZERO) && (v[8*i+:8] <= ASCII_NINE);
    end
    return ok;
  endfunction

  always_comb begin
    idleCnt_nxt = (reset || !rxPin) ? 24'h000000 : idleCnt_r + {23'h0, ~&idleCnt_r};
    zfCnt_nxt = (reset || !zeroFound) ? 32'h00000000 : zfCnt_r + {31'h0, zfCnt_r < GUARD_LIMIT};
  end

  always_ff @(posedge clk) begin
    idleCnt_r <= idleCnt_nxt;
    zfCnt_r <= zfCnt_nxt;
  end

  ////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  AST_RESET_STATE: assert property ($fell(reset) |-> txPin && !muted && !ctrl.echoOn && !ctrl.beltRun
    && ctrl.setSpeed == ZERO_FIELD && ctrl.setElev == ZERO_FIELD) else $error("outputs not at reset values");
  AST_REPLY_CAUSE: assert property ($fell(txPin) |-> idleCnt_r < TX_WIN)
    else $error("reply without a command");
  AST_ELEV_STEP: assert property (ctrl.setElev[7:0] == ASCII_ZERO || ctrl.setElev[7:0] == ASCII_FIVE)
    else $error("elevation not in half steps");
  AST_SET_DIGITS: assert property (digits(ctrl.setSpeed) && digits(ctrl.setElev))
    else $error("set point holds a non digit");
  AST_LOSS_STOP: assert property (ctrl.beltRun && ctrl.lossArmed |-> idleCnt_r <= LOSS_LIMIT + RX_WIN)
    else $error("armed belt kept running without commands");
  AST_GUARD: assert property ($rose(ctrl.beltRun) |-> zfCnt_r >= GUARD_LIMIT)
    else $error("belt started inside the guard time");
  AST_REJECT_NO_RUN: assert property (startRejected |-> !ctrl.beltRun)
    else $error("belt runs while starts are rejected");
  AST_CMD_CAUSE: assert property ($changed(ctrl.setSpeed) || $changed(ctrl.setElev) || $rose(ctrl.beltRun)
    |-> idleCnt_r <= RX_WIN) else $error("control changed without a command");
  AST_MUTE_STOP: assert property (muted |-> !ctrl.beltRun)
    else $error("belt runs while mute");

  cover property ($rose(ctrl.beltRun));
  cover property ($rose(startRejected));
  cover property ($rose(muted));
  cover property ($rose(ctrl.echoOn));
endmodule

bind treadmill_cmd tread_chk #(.LOSS_LIMIT(LOSS_LIMIT), .GUARD_LIMIT(GUARD_LIMIT)) i_tread_chk (
  .clk(clk), .reset(reset), .rxPin(rxPin), .txPin(txPin), .zeroFound(zeroFound), .meas(meas),
  .ctrl(ctrl), .startRejected(startRejected), .muted(muted));

// File: host_uart.sv
`timescale 1ns/1ps
module host_uart
  import tread_pkg::*;
(
  // Clock
  input wire logic clk,
  // Serial lines, host side
  output logic txLine,
  input wire logic rxLine
);
  logic [7:0] rxQ[$];
  logic rxBusy = 1'b0;
  int frameErr = 0;

  initial txLine = 1'b1;

  // One 8N1 frame, low bit first; line rests high between frames
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      txLine <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
  endtask

  // Mid-bit sampling; a low stop bit counts as a bad frame
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge rxLine);
      rxBusy = 1'b1;
      repeat (HALF_CYC) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk);
        b[i] = rxLine;
      end
      repeat (BIT_CYC) @(posedge clk);
      if (rxLine !== 1'b1) begin
        frameErr++;
      end
      rxQ.push_back(b);
      rxBusy = 1'b0;
    end
  end
endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb
  import tread_pkg::*;
;
  typedef logic [7:0] bq_t[$];
  // Loss time must exceed one reply plus one request
  localparam int LOSS_T = 60000;
  localparam int GUARD_T = 30000;
  localparam int SILENT_T = 400000;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic zeroFound = 1'b0;
  meas_t meas = '0;
  logic rxPin;
  logic txPin;
  logic startRejected;
  logic muted;
  ctrl_t ctrl;
  int bad_count = 0;
  int compares = 0;
  logic [31:0] spd, elv;
  bq_t none;

  always #50 clk = ~clk;

  host_uart host (.clk(clk), .txLine(rxPin), .rxLine(txPin));
  treadmill_cmd #(.LOSS_LIMIT(LOSS_T), .GUARD_LIMIT(GUARD_T), .SILENT_LIMIT(SILENT_T)) i_treadmill_cmd (
    .clk(clk), .reset(reset), .rxPin(rxPin), .txPin(txPin), .zeroFound(zeroFound),
    .meas(meas), .ctrl(ctrl), .startRejected(startRejected), .muted(muted));

  ////////////////////////////////////////
  function automatic logic [7:0] dig();
    return ASCII_ZERO + 8'($urandom_range(9));
  endfunction

  function automatic logic [7:0] ack(input logic [7:0] c);
    return c + ACK_OFFSET;
  endfunction

  // Most significant digit travels first
  function automatic bq_t split(input logic [7:0] c, input logic [31:0] v);
    return '{c, v[31:24], v[23:16], v[15:8], v[7:0]};
  endfunction

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Host waits for the whole reply before it sends again
  task automatic txn(input string nm, input bq_t cmd, input bq_t exp);
    logic [7:0] got;
    foreach (cmd[i]) begin
      repeat ($urandom_range(3)) @(posedge clk);
      host.send(cmd[i]);
    end
    for (int k = 0; k < 12 * BIT_CYC * (exp.size() + 1) && host.rxQ.size() < exp.size(); k++) begin
      @(posedge clk);
    end
    foreach (exp[i]) begin
      got = (host.rxQ.size() > 0) ? host.rxQ.pop_front() : 8'hXX;
      check(nm, {24'h0, exp[i]}, {24'h0, got});
    end
    repeat (3 * BIT_CYC) @(posedge clk);
    check({nm, " extra"}, 32'h0, 32'(host.rxQ.size() + host.rxBusy + host.frameErr));
    host.rxQ.delete();
    $display("TEST %s done", nm);
  endtask

  task automatic close_out();
    $display("Counts: compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (2600000) @(posedge clk);
    bad_count++;
    close_out();
  end

  initial begin
    void'($urandom(32'h3BB8));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    meas.actualSpeed <= {dig(), dig(), dig(), dig()};
    @(posedge clk);
    txn("start early", '{CMD_START_ARM}, none);
    check("muted", 32'h1, {31'h0, muted});
    txn("stop mute", '{CMD_STOP}, none);
    check("unmuted", 32'h0, {31'h0, muted});
    zeroFound <= 1'b1;
    txn("guard", '{CMD_START_FREE}, '{ACK_RANGE});
    check("rejected", 32'h1, {31'h0, startRejected});
    txn("sticky", '{CMD_START_FREE}, '{ACK_RANGE});
    check("belt", 32'h0, {31'h0, ctrl.beltRun});
    txn("stop", '{CMD_STOP}, '{ack(CMD_STOP)});
    check("cleared", 32'h0, {31'h0, startRejected});
    txn("unknown", '{8'h55}, '{ACK_ILLEGAL});
    spd = {dig(), dig(), dig(), dig()};
    txn("speed", split(CMD_SPEED, spd), '{ack(CMD_SPEED)});
    check("setSpeed", spd, ctrl.setSpeed);
    txn("speed digit", split(CMD_SPEED, 32'h30304130), '{ACK_RANGE});
    check("setSpeed kept", spd, ctrl.setSpeed);
    txn("elev odd", split(CMD_ELEV, 32'h30303433), '{ACK_RANGE});
    check("setElev", ZERO_FIELD, ctrl.setElev);
    txn("weight", split(CMD_WEIGHT, {dig(), dig(), dig(), dig()}), split(ack(CMD_WEIGHT), ZERO_FIELD));
    txn("protocol", '{CMD_PROTO, dig(), dig()}, split(ack(CMD_PROTO), ZERO_FIELD));
    txn("protocol status", '{REQ_PROTO}, '{ack(REQ_PROTO), ASCII_ZERO, ASCII_ZERO});
    txn("act speed", '{REQ_ACT_SPEED}, split(8'hD1, meas.actualSpeed));
    txn("start", '{CMD_START_ARM}, '{ack(CMD_START_ARM)});
    check("armed run", 32'h3, {30'h0, ctrl.beltRun, ctrl.lossArmed});
    txn("cool", '{CMD_COOL}, '{ack(CMD_COOL)});
    check("cool speed", ZERO_FIELD, ctrl.setSpeed);
    check("cool run", 32'h1, {31'h0, ctrl.beltRun});
    txn("belt status", '{REQ_BELT}, '{8'hD0, BELT_ARMED});
    repeat (LOSS_T + 2 * BIT_CYC) @(posedge clk);
    check("loss stop", 32'h0, {31'h0, ctrl.beltRun});
    txn("start free", '{CMD_START_FREE}, '{ack(CMD_START_FREE)});
    txn("free status", '{REQ_BELT}, '{ack(REQ_BELT), BELT_FREE});
    txn("echo on", '{CMD_ECHO}, '{ack(CMD_ECHO), CMD_ECHO});
    check("echo flag", 32'h1, {31'h0, ctrl.echoOn});
    elv = {ASCII_FIVE, dig(), dig(), (($urandom_range(1) != 0) ? ASCII_FIVE : ASCII_ZERO)};
    txn("elev echo", split(CMD_ELEV, elv),
        '{ack(CMD_ELEV), CMD_ELEV, elv[31:24], elv[23:16], elv[15:8], elv[7:0]});
    check("setElev", elv, ctrl.setElev);
    txn("echo off", '{CMD_ECHO}, '{ack(CMD_ECHO), CMD_ECHO});
    check("echo clear", 32'h0, {31'h0, ctrl.echoOn});
    txn("auto stop", '{CMD_AUTO_STOP}, '{ack(CMD_AUTO_STOP)});
    check("auto elev", ZERO_FIELD, ctrl.setElev);
    check("auto run", 32'h0, {31'h0, ctrl.beltRun});
    txn("stop status", '{REQ_BELT}, '{ack(REQ_BELT), BELT_STOPPED});
    close_out();
  end
endmodule
